// *** rtl/xtrig_map.svh ***
// constants and rule summary for the analyzer cross-trigger handshake
// Summary of operation
// - both sides' ports always exist; a cleared HAS_TRIG_IN or HAS_TRIG_OUT ties that side's inputs off, and a cleared HAS_TRIG_OUT also holds trigger-out low.
// - trigger-out request stays high until its acknowledge is seen high, then drops.
// - with acknowledge held low, trigger-out request stays high until re-arm clears it.
// - re-arm is accepted without any trigger-out acknowledge.
// - trigger-in acknowledge rises one cycle after the request is seen high.
// - trigger-out request rises nine cycles after trigger-in or internal trigger.
// - each acknowledge falls only after its request has been deasserted.
`ifndef XTRIG_MAP_SVH
`define XTRIG_MAP_SVH
`define XTRIG_OUT_DELAY 4'h9
`define XTRIG_PIPE_LEN 8
`endif

// *** rtl/xtrig_pkg.sv ***
// types for the analyzer cross-trigger handshake
package xtrig_pkg;
  typedef struct packed {
    logic req;
    logic ack;
  } hs_pair_t;
  typedef enum logic [1:0] {
    out_idle = 2'b00,
    out_wait = 2'b01,
    out_high = 2'b10,
    out_done = 2'b11
  } out_state_t;
endpackage

// *** rtl/xtrig_delay.sv ***
// fixed-length shift delay for the trigger event
`include "xtrig_map.svh"
module xtrig_delay
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic event_in,
  output logic event_out
);
  logic [`XTRIG_PIPE_LEN-1:0] pipe;

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pipe <= '0;
    else
      pipe <= {pipe[`XTRIG_PIPE_LEN-2:0], event_in};
  end

  assign event_out = pipe[`XTRIG_PIPE_LEN-1];
endmodule // xtrig_delay

// *** rtl/xtrig_core.sv ***
// cross-trigger handshake of the logic analyzer core
`include "xtrig_map.svh"
module xtrig_core
  import xtrig_pkg::*;
#(
  parameter bit HAS_TRIG_IN = 1'b1,
  parameter bit HAS_TRIG_OUT = 1'b1
)
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic trig_in_in,
  input wire logic trig_out_ack_in,
  input wire logic cond_met_in,
  input wire logic rearm_in,
  output logic trig_in_ack_out,
  output logic trig_out_out,
  output logic trigger_event_out
);
  ////////////////////////////////////////////////////////////////////////////
  // trigger-in side: no synchronizer, the driver shares this clock
  logic trig_in;
  logic trig_in_prev;
  logic in_event;
  logic delayed_event;
  logic armed;
  out_state_t out_state;
  hs_pair_t out_hs;

  function automatic logic may_raise(input logic ev);
    may_raise = ev && HAS_TRIG_OUT;
  endfunction

  assign trig_in = HAS_TRIG_IN ? trig_in_in : 1'b0;

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      trig_in_prev <= 1'b0;
    else
      trig_in_prev <= trig_in;
  end

  // ack follows request by one cycle
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      trig_in_ack_out <= 1'b0;
    else
      trig_in_ack_out <= trig_in;
  end

  // rising request is a trigger event; one trigger per arm
  // edge detect, so a request held high through a re-arm is not taken twice
  assign in_event = armed & ((trig_in & ~trig_in_prev) | cond_met_in);

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      armed <= 1'b1;
    // a trigger on a re-arm cycle wins only while still armed; when disarmed the re-arm wins and the trigger is lost
    else if (in_event)
      armed <= 1'b0;
    else if (rearm_in)
      armed <= 1'b1;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      trigger_event_out <= 1'b0;
    else
      trigger_event_out <= in_event;
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger-out side: eight stages plus the output flop give nine cycles
  xtrig_delay u_delay
  (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .event_in(in_event),
    .event_out(delayed_event)
  );

  // request and acknowledge travel together for the state machine and checks
  assign out_hs = '{req: trig_out_out, ack: HAS_TRIG_OUT ? trig_out_ack_in : 1'b0};

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      out_state <= out_idle;
      trig_out_out <= 1'b0;
    end
    else
    begin
      case (out_state)
        out_idle:
        begin
          if (may_raise(delayed_event))
          begin
            out_state <= out_high;
            trig_out_out <= 1'b1;
          end
        end
        out_high:
        begin
          if (out_hs.ack || rearm_in)
          begin
            out_state <= out_done;
            trig_out_out <= 1'b0;
          end
        end
        out_done:
        begin
          // an event already in flight may raise the request again after re-arm
          // waiting for ack low keeps one acknowledge from closing a request raised from idle; a raise here does not wait for ack low
          if (may_raise(delayed_event))
          begin
            out_state <= out_high;
            trig_out_out <= 1'b1;
          end
          else if (!out_hs.ack)
            out_state <= out_idle;
        end
        default:
        begin
          out_state <= out_idle;
          trig_out_out <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks: each one watches what this block drives

  AST_IN_ACK_RISE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(trig_in) |=> trig_in_ack_out) else $error("trigger-in ack late");

  AST_IN_ACK_CAUSE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(trig_in_ack_out) |-> $past(trig_in)) else $error("trigger-in ack without request");

  AST_IN_ACK_HOLD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    trig_in ##1 trig_in |-> trig_in_ack_out) else $error("trigger-in ack dropped early");

  AST_IN_ACK_DROP: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !trig_in |=> !trig_in_ack_out) else $error("trigger-in ack held after request low");

  AST_IN_ACK_FALL: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $fell(trig_in_ack_out) |-> !$past(trig_in)) else $error("trigger-in ack fell with request high");

  AST_OUT_DELAY: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    in_event && out_state == out_idle && !rearm_in ##1 !rearm_in [*8] |=> trig_out_out)
    else $error("trigger-out not raised nine cycles after event");

  AST_OUT_NOT_EARLY: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    in_event && out_state == out_idle && !rearm_in ##1 !rearm_in [*7] |=> !trig_out_out)
    else $error("trigger-out raised before nine cycles");

  AST_OUT_FROM_PIPE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(trig_out_out) |-> $past(delayed_event)) else $error("trigger-out raised without event");

  AST_OUT_HOLD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    out_hs.req && !out_hs.ack && !rearm_in |=> out_hs.req) else $error("trigger-out dropped without ack");

  AST_OUT_STATE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    out_hs.req |-> out_state == out_high) else $error("trigger-out high outside request state");

  AST_OUT_ACK_DROP: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    trig_out_out && out_hs.ack && !delayed_event |=> !trig_out_out) else $error("trigger-out held after ack");

  AST_OUT_DONE_WAIT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    out_state == out_done && out_hs.ack && !delayed_event |=> out_state == out_done && !trig_out_out)
    else $error("trigger-out left done state with ack high");

  AST_OUT_REARM: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    trig_out_out && rearm_in && !delayed_event |=> !trig_out_out) else $error("re-arm did not clear trigger-out");

  AST_REARM_NO_ACK: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rearm_in && !in_event |=> armed) else $error("re-arm refused");

  AST_EVENT_FROM_IN: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    armed && $rose(trig_in) |=> trigger_event_out) else $error("trigger-in not taken as event");

  AST_EVENT_FROM_COND: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    armed && cond_met_in |=> trigger_event_out) else $error("trigger condition not taken as event");

  AST_EVENT_ONCE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    trigger_event_out |-> !armed) else $error("still armed after trigger event");

  AST_EVENT_PULSE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    trigger_event_out |=> !trigger_event_out) else $error("trigger event longer than one cycle");

  AST_EVENT_REFUSED: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !armed |=> !trigger_event_out) else $error("trigger event while disarmed");

  AST_IN_EVENT_EDGE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    armed && trig_in && $past(trig_in) && !cond_met_in |=> !trigger_event_out)
    else $error("held trigger-in taken twice");
endmodule // xtrig_core

// *** verif/xtrig_partner.sv ***
// far-side model that acknowledges the trigger-out request
module xtrig_partner
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic trig_out_in,
  input wire logic ack_en_in,
  output logic trig_out_ack_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ack follows request
  // ack low models a tied-low acknowledge; the bench may hold it off to answer slowly
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      trig_out_ack_out <= 1'b0;
    else
      trig_out_ack_out <= trig_out_in & ack_en_in;
  end
endmodule // xtrig_partner

// *** verif/logic_analyzer_cross_trigger_tb.sv ***
// self-checking bench for the cross-trigger handshake
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; $display("ERROR %0t mismatch", $time); end end
module logic_analyzer_cross_trigger_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst_n, trig_in, cond_met, rearm, ack_en, ack, in_ack, trig_out, trig_event;
  int fail_count = 0;
  int num_checks = 0;
  xtrig_core DUT (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .trig_in_in(trig_in), .trig_out_ack_in(ack),
    .cond_met_in(cond_met), .rearm_in(rearm), .trig_in_ack_out(in_ack), .trig_out_out(trig_out),
    .trigger_event_out(trig_event));
  xtrig_partner partner (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .trig_out_in(trig_out), .ack_en_in(ack_en),
    .trig_out_ack_out(ack));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task summarize();
    if (fail_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // stimulus driven on clock
  // drives one stimulus set, then checks n cycles; trig_out expected high for cycles lo..hi
  task step(input logic ti, cm, ra, ae, input int n, lo, hi, input logic ev);
    @(posedge ref_clk);
    trig_in <= ti;
    cond_met <= cm;
    rearm <= ra;
    ack_en <= ae;
    for (int i = 1; i <= n; i++)
    begin
      @(posedge ref_clk);
      cond_met <= 1'b0;
      rearm <= 1'b0;
      #1;
      `CHK(in_ack, trig_in)
      `CHK(trig_event, ev & (i == 1))
      `CHK(trig_out, i >= lo && i <= hi)
    end
  endtask
  task t_trig_in();
    step(1'b1, 1'b0, 1'b0, 1'b1, 11, 9, 10, 1'b1);
    step(1'b0, 1'b0, 1'b0, 1'b1, 2, 1, 0, 1'b0);
  endtask
  task t_refused();
    // disarmed: no event and no request
    step(1'b0, 1'b1, 1'b0, 1'b1, 12, 1, 0, 1'b0);
    step(1'b1, 1'b0, 1'b0, 1'b1, 3, 1, 0, 1'b0);
    step(1'b0, 1'b0, 1'b0, 1'b1, 2, 1, 0, 1'b0);
  endtask
  task t_rearm_clash();
    // re-arm, then a trigger on a re-arm cycle spends that arm
    step(1'b0, 1'b0, 1'b1, 1'b1, 1, 1, 0, 1'b0);
    step(1'b0, 1'b1, 1'b1, 1'b1, 11, 9, 10, 1'b1);
    step(1'b0, 1'b1, 1'b0, 1'b1, 2, 1, 0, 1'b0);
  endtask
  task t_no_ack();
    step(1'b0, 1'b0, 1'b1, 1'b0, 1, 1, 0, 1'b0);
    step(1'b0, 1'b1, 1'b0, 1'b0, 30, 9, 30, 1'b1);
    step(1'b0, 1'b0, 1'b1, 1'b0, 2, 1, 0, 1'b0);
    step(1'b0, 1'b1, 1'b0, 1'b1, 11, 9, 10, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    trig_in = 1'b0;
    cond_met = 1'b0;
    rearm = 1'b0;
    ack_en = 1'b1;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_trig_in();
    t_refused();
    t_no_ack();
    t_rearm_clash();
    summarize();
  end
  // whole run needs about 105 cycles
  initial
  begin
    repeat (1000) @(posedge ref_clk);
    fail_count++;
    summarize();
  end
endmodule // logic_analyzer_cross_trigger_tb
